/* File: logic/atir_pkg.sv */
// Package of constants for the acquisition trigger and input routing block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package atir_pkg;
  // Clock rate and strobe timing.
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned STROBE_LOW_NS   = 500;
  localparam int unsigned STROBE_CYCLES   = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STROBE_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] IRQ_OFF    = 8'h0C;
  localparam logic [7:0] MASK_OFF   = 8'h10;
  localparam logic [7:0] COUNT_OFF  = 8'h14;
  // Control field positions.
  localparam int unsigned CTRL_ENABLE  = 0;
  localparam int unsigned CTRL_PRETRIG = 1;
  localparam int unsigned CTRL_SCAN    = 2;
  localparam int unsigned CTRL_EXTUPD  = 3;
  localparam int unsigned CTRL_TIMIRQ  = 4;
  localparam int unsigned CTRL_SENSEG  = 5;
  localparam int unsigned CTRL_MODE_LO = 6;
  localparam int unsigned CTRL_CHAN_LO = 8;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  // Interrupt bit positions.
  localparam int unsigned IRQ_CONV  = 0;
  localparam int unsigned IRQ_TRIG  = 1;
  localparam int unsigned IRQ_TIMED = 2;
  localparam int unsigned IRQ_W     = 3;
  // Input modes.
  localparam logic [1:0] MODE_PAIRED = 2'h0;
  localparam logic [1:0] MODE_REF    = 2'h1;
  localparam logic [1:0] MODE_NONREF = 2'h2;
  // Analog negative input selections.
  localparam logic [1:0] NEG_GROUND = 2'h0;
  localparam logic [1:0] NEG_CHAN   = 2'h1;
  localparam logic [1:0] NEG_SENSE  = 2'h2;
  // Acquisition sequence states.
  typedef enum logic [2:0] {
    ATIR_IDLE = 3'b001,
    ATIR_PRE  = 3'b010,
    ATIR_POST = 3'b100
  } atir_state_t;
endpackage

/* File: logic/atir_top.sv */
// Trigger, conversion, strobe, update and input routing control.
// Assumes external inputs are asynchronous to aclk and an AXI4-Lite master.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - One scan pulse per conversion when scanning.
// - Scan pulse rises after sample taken.
// - Strobe write gives 500 ns low.
// - Posttrigger starts on trigger falling edge.
// - Pretrigger: first edge pre, second post.
// - Gate low inhibits conversions.
// - Convert falling edge starts one conversion.
// - Ignore converts outside sequence or gated.
// - Update falling edge loads both converters.
// - Update edge raises timed interrupt if enabled.
// - Nonreferenced mode: sense to negative input.
// - Other modes: sense grounded or open.
// - Single-ended routes any of 16.
// - Differential pairs channels 0-7 with 8-15.
module atir_top #(
  parameter int unsigned CHANNELS = 16
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External connector inputs, active low.
  input  wire logic        ext_acq_trigger_n,
  input  wire logic        ext_conv_gate_n,
  input  wire logic        ext_conv_request_n,
  input  wire logic        ext_output_update_trigger_n,
  // Converter handshake and connector outputs.
  output logic             convert_start,
  input  wire logic        sample_taken,
  output logic             scan_pulse,
  output logic             external_strobe_n,
  output logic             output_update_load,
  output logic             acq_post_phase,
  // Analog routing selects.
  output logic [3:0]       pos_channel,
  output logic [3:0]       neg_channel,
  output logic [1:0]       neg_select,
  output logic             sense_to_ground,
  // Interrupt.
  output logic             irq
);
  if (CHANNELS != 16) begin : g_chan_chk  // The routing serves sixteen channels only.
    $error("atir_top serves exactly sixteen channels");
  end

  logic [31:0] ctrl_reg;
  logic [atir_pkg::IRQ_W-1:0] stat_reg;
  logic [atir_pkg::IRQ_W-1:0] mask_reg;
  logic [15:0] count_reg;
  logic [7:0]  strobe_cnt_reg;
  atir_pkg::atir_state_t state_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  s1_reg, s2_reg, s3_reg;
  logic        busy_reg;

  // Write address and data latch independently; a response follows both.
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  wire   wr_go = aw_hold_reg && w_hold_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_map = awaddr_reg inside {atir_pkg::CTRL_OFF, atir_pkg::STROBE_OFF,
                                   atir_pkg::MASK_OFF};
  assign s_axi_bresp = wr_map ? 2'h0 : 2'h2;

  // Control and mask registers, no byte strobes on this block.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= atir_pkg::CTRL_RESET;
      mask_reg <= '0;
    end else if (wr_go) begin
      if (awaddr_reg == atir_pkg::CTRL_OFF) ctrl_reg <= wdata_reg;
      if (awaddr_reg == atir_pkg::MASK_OFF) mask_reg <= wdata_reg[atir_pkg::IRQ_W-1:0];
    end
  end

  // Read channel; answer one cycle after address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  wire   rd_go = s_axi_arvalid && s_axi_arready;
  wire   rd_irq = rd_go && (s_axi_araddr == atir_pkg::IRQ_OFF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        atir_pkg::CTRL_OFF:  s_axi_rdata <= ctrl_reg;
        atir_pkg::STAT_OFF:  s_axi_rdata <= {26'h0, s3_reg[1], busy_reg,
                                             external_strobe_n, state_reg};
        atir_pkg::IRQ_OFF:   s_axi_rdata <= {29'h0, stat_reg};
        atir_pkg::MASK_OFF:  s_axi_rdata <= {29'h0, mask_reg};
        atir_pkg::COUNT_OFF: s_axi_rdata <= {16'h0, count_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // two-stage synchronisers.
  // Bits are trigger, gate, convert, update; stage three feeds edge detect.
  wire [3:0] pins_n = {ext_output_update_trigger_n, ext_conv_request_n,
                       ext_conv_gate_n, ext_acq_trigger_n};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 4'hF;
      s2_reg <= 4'hF;
      s3_reg <= 4'hF;
    end else begin
      s1_reg <= pins_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire [3:0] fall = s3_reg & ~s2_reg;
  wire gate_on = s2_reg[1];

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_reg[atir_pkg::CTRL_ENABLE]) begin
      state_reg <= atir_pkg::ATIR_IDLE;
    end else begin
      case (state_reg)
        atir_pkg::ATIR_IDLE: if (fall[0]) begin
          state_reg <= ctrl_reg[atir_pkg::CTRL_PRETRIG] ? atir_pkg::ATIR_PRE
                                                        : atir_pkg::ATIR_POST;
        end
        atir_pkg::ATIR_PRE:  if (fall[0]) state_reg <= atir_pkg::ATIR_POST;
        atir_pkg::ATIR_POST: state_reg <= atir_pkg::ATIR_POST;
        default:             state_reg <= atir_pkg::ATIR_IDLE;
      endcase
    end
  end
  assign acq_post_phase = (state_reg == atir_pkg::ATIR_POST);

  // ignored outside a sequence or while busy.
  wire conv_ok = fall[2] && gate_on && (state_reg != atir_pkg::ATIR_IDLE) && !busy_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      convert_start <= 1'b0;
      busy_reg      <= 1'b0;
      count_reg     <= 16'h0000;
    end else begin
      convert_start <= conv_ok;
      if (conv_ok) begin
        busy_reg  <= 1'b1;
        count_reg <= count_reg + 16'h0001;
      end else if (sample_taken) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_pulse <= 1'b0;
    end else begin
      scan_pulse <= busy_reg && sample_taken && ctrl_reg[atir_pkg::CTRL_SCAN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_cnt_reg <= 8'h00;
    end else if (wr_go && awaddr_reg == atir_pkg::STROBE_OFF) begin
      strobe_cnt_reg <= 8'(atir_pkg::STROBE_CYCLES);
    end else if (strobe_cnt_reg != 8'h00) begin
      strobe_cnt_reg <= strobe_cnt_reg - 8'h01;
    end
  end
  assign external_strobe_n = (strobe_cnt_reg == 8'h00);

  wire upd_fall = fall[3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_update_load <= 1'b0;
    end else begin
      output_update_load <= upd_fall && ctrl_reg[atir_pkg::CTRL_EXTUPD];
    end
  end

  // sticky interrupt status, read clears, set wins.
  wire [atir_pkg::IRQ_W-1:0] ev = {upd_fall && ctrl_reg[atir_pkg::CTRL_TIMIRQ],
                         fall[0] && (state_reg != atir_pkg::ATIR_POST)
                           && ctrl_reg[atir_pkg::CTRL_ENABLE], conv_ok};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (rd_irq ? '0 : stat_reg) | ev;
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // differential pairs channel with plus eight.
  wire [1:0] mode = ctrl_reg[atir_pkg::CTRL_MODE_LO +: 2];
  wire [3:0] chan = ctrl_reg[atir_pkg::CTRL_CHAN_LO +: 4];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_channel     <= 4'h0;
      neg_channel     <= 4'h8;
      neg_select      <= atir_pkg::NEG_CHAN;
      sense_to_ground <= 1'b0;
    end else begin
      sense_to_ground <= (mode != atir_pkg::MODE_NONREF) && ctrl_reg[atir_pkg::CTRL_SENSEG];
      if (mode == atir_pkg::MODE_PAIRED) begin
        pos_channel <= {1'b0, chan[2:0]};
        neg_channel <= {1'b1, chan[2:0]};
        neg_select  <= atir_pkg::NEG_CHAN;
      end else begin
        pos_channel <= chan;
        neg_channel <= 4'h0;
        neg_select  <= (mode == atir_pkg::MODE_NONREF) ? atir_pkg::NEG_SENSE
                                                       : atir_pkg::NEG_GROUND;
      end
    end
  end

  // Assertions.
  localparam int STROBE_TAIL = atir_pkg::STROBE_CYCLES - 8;  // Low cycles after the first eight.
  property p_strobe_len;
    @(posedge aclk) disable iff (!aresetn)
      $fell(external_strobe_n) |-> !external_strobe_n [*8] ##STROBE_TAIL !external_strobe_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
  property p_scan_once;
    @(posedge aclk) disable iff (!aresetn)
      scan_pulse |-> $past(busy_reg) ##1 !scan_pulse;
  endproperty
  a_scan_once: assert property (p_scan_once) else $error("scan pulse no conversion");
  property p_scan_after;
    @(posedge aclk) disable iff (!aresetn) scan_pulse |-> $past(sample_taken);
  endproperty
  a_scan_after: assert property (p_scan_after) else $error("scan before sample");
  property p_gate;
    @(posedge aclk) disable iff (!aresetn) convert_start |-> $past(gate_on);
  endproperty
  a_gate: assert property (p_gate) else $error("conversion while gated");
  property p_idle;
    @(posedge aclk) disable iff (!aresetn)
      convert_start |-> $past(state_reg) != atir_pkg::ATIR_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("conversion outside sequence");
  property p_conv;
    @(posedge aclk) disable iff (!aresetn) conv_ok |=> convert_start;
  endproperty
  a_conv: assert property (p_conv) else $error("convert edge lost");
  property p_post;
    @(posedge aclk) disable iff (!aresetn)
      (state_reg == atir_pkg::ATIR_PRE && fall[0] && ctrl_reg[0]) |=> acq_post_phase;
  endproperty
  a_post: assert property (p_post) else $error("second edge missed");
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      (state_reg == atir_pkg::ATIR_IDLE && fall[0] && ctrl_reg[1:0] == 2'b01) |=> acq_post_phase;
  endproperty
  a_start: assert property (p_start) else $error("trigger edge missed");
  property p_timed;
    @(posedge aclk) disable iff (!aresetn) ev[2] |=> stat_reg[2];
  endproperty
  a_timed: assert property (p_timed) else $error("timed irq lost");
  property p_nonref_sense;
    @(posedge aclk) disable iff (!aresetn)
      mode == atir_pkg::MODE_NONREF |=> neg_select == atir_pkg::NEG_SENSE && !sense_to_ground;
  endproperty
  a_nonref_sense: assert property (p_nonref_sense) else $error("sense not routed");
  property p_pair;
    @(posedge aclk) disable iff (!aresetn)
      mode == atir_pkg::MODE_PAIRED |=> neg_channel == (pos_channel | 4'h8);
  endproperty
  a_pair: assert property (p_pair) else $error("pair wrong");
  c_scan:   cover property (@(posedge aclk) scan_pulse);
  c_strobe: cover property (@(posedge aclk) $rose(external_strobe_n));
  c_pre:    cover property (@(posedge aclk) state_reg == atir_pkg::ATIR_PRE ##1 acq_post_phase);
endmodule

/* File: verif/atir_instr.sv */
// Instrument model: connector trigger pins and the converter's sample signal.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module atir_instr (
  // Clock and converter handshake.
  input  wire logic aclk,
  input  wire logic convert_start,
  output logic      sample_taken,
  // Connector pins, active low.
  output logic      ext_acq_trigger_n,
  output logic      ext_conv_gate_n,
  output logic      ext_conv_request_n,
  output logic      ext_output_update_trigger_n
);
  logic [3:0] pins_n  = 4'hf;
  logic [2:0] hold_sr = 3'h0;
  // Pins rest high between edges; the gate pin keeps the level that gate sets.
  assign {ext_output_update_trigger_n, ext_conv_request_n} = pins_n[3:2];
  assign {ext_conv_gate_n, ext_acq_trigger_n} = pins_n[1:0];
  // The converter holds its sample three cycles after a start.
  always @(posedge aclk) hold_sr <= {hold_sr[1:0], convert_start};
  assign sample_taken = hold_sr[2];
  // Drives one falling edge, holds it four cycles, then releases.
  task automatic fall(input int k);
    @(posedge aclk);
    pins_n[k] <= 1'b0;
    repeat (4) @(posedge aclk);
    pins_n[k] <= 1'b1;
  endtask
  // Sets the gate level.
  task automatic gate(input logic v);
    @(posedge aclk);
    pins_n[1] <= v;
  endtask
endmodule

/* File: verif/atir_bench.sv */
// Self-checking bench for the trigger and input routing block.
// Assumes the instrument model drives the connector and converter.
`timescale 1ns/1ps
module acquisition_trigger_and_input_routing_bench;
  logic        aclk = 1'b0, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, pos_channel, neg_channel;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, st_prev = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, neg_select, rsp;
  logic        ext_acq_trigger_n, ext_conv_gate_n, ext_conv_request_n;
  logic        ext_output_update_trigger_n, convert_start, sample_taken, scan_pulse;
  logic        external_strobe_n, output_update_load, acq_post_phase, sense_to_ground, irq;
  int          miscompares = 0, total_checks = 0, cyc = 0, bad_scan = 0;
  int          n_conv = 0, n_scan = 0, n_upd = 0, n_strb = 0, c0;
  atir_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_acq_trigger_n, .ext_conv_gate_n,
    .ext_conv_request_n, .ext_output_update_trigger_n, .convert_start, .sample_taken,
    .scan_pulse, .external_strobe_n, .output_update_load, .acq_post_phase, .pos_channel,
    .neg_channel, .neg_select, .sense_to_ground, .irq);
  atir_instr ext_u (.aclk, .convert_start, .sample_taken, .ext_acq_trigger_n,
    .ext_conv_gate_n, .ext_conv_request_n, .ext_output_update_trigger_n);
  // Clock of 10 ns period.
  always #5 aclk = ~aclk;
  // Counts design pulses at the falling edge, clear of the launching edge.
  always @(negedge aclk) begin
    if (convert_start === 1'b1) n_conv++;
    if (scan_pulse === 1'b1) n_scan++;
    if (scan_pulse === 1'b1 && st_prev !== 1'b1) bad_scan++;
    if (output_update_load === 1'b1) n_upd++;
    if (aresetn && external_strobe_n === 1'b0) n_strb++;
    st_prev = sample_taken;
  end
  // Cuts a hang short.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Compares one value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Prints the counts and the verdict.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bus write; readies are sampled at the falling edge and acted on at the next rising edge.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    chk(b, 1, "write answer");
  endtask
  // Bus read.
  task automatic axr(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) break;
    end
    s_axi_rready <= 1'b0;
    chk(r, 1, "read answer");
  endtask
  // Writes mode, channel and sense ground, then checks the routing.
  task automatic route(input logic [1:0] m, input logic [3:0] ch, input logic sg,
                       input logic [3:0] ep, input logic [1:0] es, input logic eg);
    axw(atir_pkg::CTRL_OFF, {20'h0_0000, ch, m, sg, 5'h00});
    repeat (3) @(posedge aclk);
    chk(pos_channel, ep, "positive channel");
    chk(neg_select, es, "negative select");
    chk(sense_to_ground, eg, "sense ground");
  endtask
  task automatic t_reset();
    chk(external_strobe_n, 1, "strobe idle");
    chk({pos_channel, neg_channel, neg_select}, {4'h0, 4'h8, atir_pkg::NEG_CHAN}, "routing");
    chk({irq, acq_post_phase}, 2'h0, "irq and phase");
    axr(atir_pkg::CTRL_OFF);
    chk(rd, atir_pkg::CTRL_RESET, "control reset");
    $display("test reset done");
  endtask
  task automatic t_route();
    route(atir_pkg::MODE_PAIRED, 4'hd, 1'b1, 4'h5, atir_pkg::NEG_CHAN, 1'b1);
    chk(neg_channel, 4'hd, "paired channel");
    route(atir_pkg::MODE_REF, 4'hf, 1'b0, 4'hf, atir_pkg::NEG_GROUND, 1'b0);
    route(atir_pkg::MODE_NONREF, 4'h0, 1'b1, 4'h0, atir_pkg::NEG_SENSE, 1'b0);
    $display("test routing done");
  endtask
  task automatic t_strobe();
    n_strb = 0;
    axw(atir_pkg::STROBE_OFF, 32'h0000_0000);
    chk(rsp, 2'h0, "strobe write response");
    repeat (70) @(posedge aclk);
    chk(n_strb, atir_pkg::STROBE_CYCLES, "strobe low cycles");
    chk(external_strobe_n, 1, "strobe released");
    $display("test strobe done");
  endtask
  task automatic t_conv();
    axw(atir_pkg::CTRL_OFF, 32'h0000_0005);
    c0 = n_conv;
    ext_u.fall(2);
    repeat (12) @(posedge aclk);
    chk(n_conv, c0, "convert while idle");
    ext_u.fall(0);
    repeat (8) @(posedge aclk);
    chk(acq_post_phase, 1, "posttrigger start");
    ext_u.gate(1'b0);
    ext_u.fall(2);
    repeat (12) @(posedge aclk);
    chk(n_conv, c0, "convert while gated");
    ext_u.gate(1'b1);
    repeat (2) begin
      ext_u.fall(2);
      repeat (12) @(posedge aclk);
    end
    chk(n_conv, c0 + 2, "one conversion per edge");
    chk(n_scan, n_conv - c0, "scan pulse count");
    chk(bad_scan, 0, "scan before sample");
    axr(atir_pkg::COUNT_OFF);
    chk(rd, 32'h0000_0002, "conversion count");
    axw(atir_pkg::CTRL_OFF, 32'h0000_0000);
    $display("test conversion done");
  endtask
  task automatic t_pretrig();
    axw(atir_pkg::CTRL_OFF, 32'h0000_0003);
    ext_u.fall(0);
    repeat (8) @(posedge aclk);
    axr(atir_pkg::STAT_OFF);
    chk(rd[2:0], atir_pkg::ATIR_PRE, "pretrigger phase");
    chk(acq_post_phase, 0, "not yet post");
    ext_u.fall(0);
    repeat (8) @(posedge aclk);
    chk(acq_post_phase, 1, "second edge to post");
    axw(atir_pkg::CTRL_OFF, 32'h0000_0000);
    $display("test pretrigger done");
  endtask
  task automatic t_update();
    axw(atir_pkg::MASK_OFF, 32'h0000_0004);
    axw(atir_pkg::CTRL_OFF, 32'h0000_0018);
    c0 = n_upd;
    ext_u.fall(3);
    repeat (8) @(posedge aclk);
    chk(n_upd, c0 + 1, "update load");
    chk(irq, 1, "timed interrupt");
    axr(atir_pkg::IRQ_OFF);
    chk(rd[2], 1, "timed status");
    repeat (2) @(posedge aclk);
    chk(irq, 0, "cleared by read");
    axw(atir_pkg::CTRL_OFF, 32'h0000_0000);
    ext_u.fall(3);
    repeat (8) @(posedge aclk);
    chk(n_upd, c0 + 1, "update not selected");
    chk(irq, 0, "timed disabled");
    $display("test update done");
  endtask
  task automatic t_unmapped();
    axr(8'h40);
    chk({rsp, rd}, {2'h2, 32'h0000_0000}, "unmapped read");
    axw(8'h40, 32'h0000_ffff);
    chk(rsp, 2'h2, "unmapped write");
    $display("test unmapped done");
  endtask
  // Main sequence.
  initial begin
    aresetn       <= 1'b0;
    s_axi_awaddr  <= 8'h00;
    s_axi_araddr  <= 8'h00;
    s_axi_wdata   <= 32'h0000_0000;
    s_axi_wstrb   <= 4'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_route();
    t_strobe();
    t_conv();
    t_pretrig();
    t_update();
    t_unmapped();
    final_report();
  end
endmodule
